// >>> src/pfadc_pkg.sv
package pfadc_pkg;

  // ********************************************************
  // Register map and field layout
  // ********************************************************
  localparam logic [7:0] OFS_ONESHOT = 8'h00;
  localparam logic [7:0] OFS_CONT = 8'h04;
  localparam logic [7:0] OFS_DEADBAND = 8'h08;
  localparam logic [7:0] OFS_RED = 8'h0C;
  localparam logic [7:0] OFS_FED = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  localparam int unsigned OS_ACT_A_LSB = 0;
  localparam int unsigned OS_TRIG_A_BIT = 2;
  localparam int unsigned OS_ACT_B_LSB = 3;
  localparam int unsigned OS_TRIG_B_BIT = 5;
  localparam int unsigned OS_RELOAD_LSB = 6;
  localparam int unsigned CF_A_LSB = 0;
  localparam int unsigned CF_B_LSB = 2;
  localparam int unsigned DB_MODE_LSB = 0;
  localparam int unsigned DB_POL_LSB = 2;
  localparam int unsigned DB_SRC_LSB = 4;
  localparam int unsigned DB_HALF_BIT = 15;
  localparam int unsigned DELAY_W_DEF = 10;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } pfadc_action_t;

  typedef enum logic [1:0] {
    RLD_ZERO = 2'b00,
    RLD_PERIOD = 2'b01,
    RLD_EITHER = 2'b10,
    RLD_IMMED = 2'b11
  } pfadc_reload_t;

  typedef enum logic {
    BUS_ACK = 1'b0,
    BUS_IDLE = 1'b1
  } pfadc_bus_t;

  typedef struct packed {
    logic half;
    logic [1:0] src;
    logic [1:0] pol;
    logic [1:0] mode;
  } pfadc_db_ctrl_t;

  typedef struct packed {
    logic [1:0] action;
    logic fire;
    logic [1:0] cont;
  } pfadc_force_cfg_t;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam pfadc_db_ctrl_t RST_DB = 7'h00;
  localparam pfadc_reload_t RST_RELOAD = RLD_ZERO;
  localparam logic [3:0] RST_CONT = 4'h0;
  localparam logic [1:0] RST_ACT = 2'h0;

  // ********************************************************
  // Shared functions
  // ********************************************************
  function automatic logic apply_action(input logic level,
                                        input logic [1:0] act);
    logic r;
    r = level;
    case (act)
      ACT_LOW: r = 1'b0;
      ACT_HIGH: r = 1'b1;
      ACT_TOGGLE: r = ~level;
      default: r = level;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [3:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

endpackage

// >>> src/pfadc_force_unit.sv
`timescale 1ns/1ns
module pfadc_force_unit (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_time_base_tick,
  input wire logic [1:0] i_event_action,
  input wire pfadc_pkg::pfadc_force_cfg_t i_cfg,
  output logic o_level
);

  typedef struct packed {
    logic level;
  } pfadc_fu_state_t;

  pfadc_fu_state_t q;
  pfadc_fu_state_t d;

  // ********************************************************
  // Level update on the time-base tick
  // ********************************************************
  // Continuous force outranks the one-shot, which outranks events.
  always_comb begin
    d = q;
    if (i_time_base_tick) begin
      case (i_cfg.cont)
        pfadc_pkg::ACT_LOW: d.level = 1'b0;
        pfadc_pkg::ACT_HIGH: d.level = 1'b1;
        default: begin
          if (i_cfg.fire) begin
            d.level = pfadc_pkg::apply_action(q.level,
                                              i_cfg.action);
          end else begin
            d.level = pfadc_pkg::apply_action(q.level,
                                              i_event_action);
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.level;

endmodule

// >>> src/pfadc_edge_delay.sv
`timescale 1ns/1ns
module pfadc_edge_delay #(
  parameter int unsigned DELAY_W = 10
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_step,
  input wire logic i_in,
  input wire logic [DELAY_W-1:0] i_delay,
  output logic o_out
);

  if (DELAY_W < 1 || DELAY_W > 16) begin : g_bad_width
    $error("Delay width must lie between 1 and 16.");
  end

  typedef struct packed {
    logic [DELAY_W-1:0] cnt;
    logic out;
  } pfadc_ed_state_t;

  pfadc_ed_state_t q;
  pfadc_ed_state_t d;

  // ********************************************************
  // Rising-edge delay counter
  // ********************************************************
  // The counter saturates at the delay, so it never wraps.
  always_comb begin
    d = q;
    if (!i_in) begin
      d.cnt = '0;
      d.out = 1'b0;
    end else if (q.cnt >= i_delay) begin
      d.out = 1'b1;
    end else if (i_step) begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_out = q.out;

endmodule

// >>> src/pfadc_ctrl.sv
`timescale 1ns/1ns
// Contract
// - One-shot force on A applies action: none, low, high, toggle.
// - One-shot force is never gated by counter direction.
// - B continuous force: 01 low, 10 high, 00 and 11 off.
// - A continuous force: 01 low, 10 high, 00 and 11 off.
// - Immediate mode: new force acts at next time-base tick.
// - Shadow mode: force acts at tick after shadow transfer.
// - Reload select field chooses immediate or shadow operation.
// - Reload on zero, period, either, or bypass shadow entirely.
// - Writing 1 to trigger A fires once; reads 0; 0 ignored.
// - Half-cycle bit clocks delay counters at double tick rate.
// - Source 00 feeds A into both delay paths.
// - Source 01: B to rising delay, A to falling delay.
// - Source 10: A to rising delay, B to falling delay.
// - Source 11 feeds B into both delay paths.
// - Polarity bits each invert one delayed signal.
// - Polarity 00 none, 01 A, 10 B, 11 both inverted.
// - Mode 00 bypass, 01 falling on B, 10 rising on A, 11 both.
module pfadc_ctrl #(
  parameter int unsigned DELAY_W = pfadc_pkg::DELAY_W_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_time_base_tick,
  input wire logic i_tick_x2,
  input wire logic i_cnt_zero,
  input wire logic i_cnt_period,
  input wire logic [1:0] i_event_action_a,
  input wire logic [1:0] i_event_action_b,
  output logic o_qualified_out_a,
  output logic o_qualified_out_b,
  output logic o_db_out_a,
  output logic o_db_out_b
);

  if (DELAY_W < 1 || DELAY_W > 16) begin : g_bad_width
    $error("Delay width must lie between 1 and 16.");
  end

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    pfadc_pkg::pfadc_bus_t bus;
    logic [31:0] rdata;
    pfadc_pkg::pfadc_reload_t reload;
    logic [1:0] act_b;
    logic [1:0] act_a;
    logic pend_a;
    logic pend_b;
    logic [3:0] cont_shadow;
    logic [3:0] cont_active;
    pfadc_pkg::pfadc_db_ctrl_t db;
    logic [DELAY_W-1:0] red;
    logic [DELAY_W-1:0] fed;
    logic out_a;
    logic out_b;
  } pfadc_state_t;

  localparam pfadc_state_t ST_RST = '{
    bus: pfadc_pkg::BUS_IDLE,
    reload: pfadc_pkg::RST_RELOAD,
    act_b: pfadc_pkg::RST_ACT,
    act_a: pfadc_pkg::RST_ACT,
    cont_shadow: pfadc_pkg::RST_CONT,
    cont_active: pfadc_pkg::RST_CONT,
    db: pfadc_pkg::RST_DB,
    default: '0
  };

  pfadc_state_t q;
  pfadc_state_t d;

  logic acc;
  logic wr;
  logic [15:0] wv;
  logic [15:0] os_rb;
  logic [15:0] cont_rb;
  logic [15:0] db_rb;
  logic [15:0] os_new;
  logic [15:0] cont_new;
  logic [15:0] db_new;
  logic [15:0] red_new;
  logic [15:0] fed_new;
  logic [15:0] status;
  logic [15:0] rsel;
  logic trig_a;
  logic trig_b;
  logic ld_evt;
  logic step;
  logic red_src;
  logic fed_src;
  logic lvl_a;
  logic lvl_b;
  logic red_out;
  logic fed_raw;
  logic fed_out;
  pfadc_pkg::pfadc_force_cfg_t cfg_a;
  pfadc_pkg::pfadc_force_cfg_t cfg_b;

  // ********************************************************
  // Force units for the two qualified outputs
  // ********************************************************
  // The pending flag is honoured on a tick whatever the count
  // direction, so no direction input exists here.
  assign cfg_a = '{action: q.act_a,
                   fire: q.pend_a & i_time_base_tick,
                   cont: q.cont_active[pfadc_pkg::CF_A_LSB +: 2]};
  assign cfg_b = '{action: q.act_b,
                   fire: q.pend_b & i_time_base_tick,
                   cont: q.cont_active[pfadc_pkg::CF_B_LSB +: 2]};

  pfadc_force_unit u_force_a (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_time_base_tick(i_time_base_tick),
    .i_event_action(i_event_action_a),
    .i_cfg(cfg_a),
    .o_level(lvl_a)
  );

  pfadc_force_unit u_force_b (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_time_base_tick(i_time_base_tick),
    .i_event_action(i_event_action_b),
    .i_cfg(cfg_b),
    .o_level(lvl_b)
  );

  // ********************************************************
  // Dead-band delay paths
  // ********************************************************
  assign step = q.db.half ? i_tick_x2 : i_time_base_tick;
  // Bit 4 steers the rising path, bit 5 the falling path.
  assign red_src = q.db.src[0] ? lvl_b : lvl_a;
  assign fed_src = q.db.src[1] ? lvl_b : lvl_a;

  pfadc_edge_delay #(
    .DELAY_W(DELAY_W)
  ) u_red (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_step(step),
    .i_in(red_src),
    .i_delay(q.red),
    .o_out(red_out)
  );

  // A falling-edge delay is a rising-edge delay of the inverse.
  pfadc_edge_delay #(
    .DELAY_W(DELAY_W)
  ) u_fed (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_step(step),
    .i_in(~fed_src),
    .i_delay(q.fed),
    .o_out(fed_raw)
  );

  assign fed_out = ~fed_raw;

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb begin
    d = q;
    acc = (q.bus == pfadc_pkg::BUS_ACK);
    wr = acc & i_avs_write;
    wv = i_avs_writedata[15:0];
    os_rb = {8'h00, q.reload, 1'b0, q.act_b, 1'b0, q.act_a};
    cont_rb = {12'h000, q.cont_shadow};
    db_rb = {q.db.half, 9'h000, q.db.src,
             q.db.pol, q.db.mode};
    os_new = pfadc_pkg::merge16(os_rb, wv, i_avs_byteenable);
    cont_new = pfadc_pkg::merge16(cont_rb, wv, i_avs_byteenable);
    db_new = pfadc_pkg::merge16(db_rb, wv, i_avs_byteenable);
    red_new = pfadc_pkg::merge16(16'(q.red), wv, i_avs_byteenable);
    fed_new = pfadc_pkg::merge16(16'(q.fed), wv, i_avs_byteenable);
    status = {6'h00, q.pend_b, q.pend_a, q.cont_active,
              q.out_b, q.out_a, lvl_b, lvl_a};
    trig_a = wr & (i_avs_address == pfadc_pkg::OFS_ONESHOT) &
             i_avs_byteenable[0] &
             wv[pfadc_pkg::OS_TRIG_A_BIT];
    trig_b = wr & (i_avs_address == pfadc_pkg::OFS_ONESHOT) &
             i_avs_byteenable[0] & wv[pfadc_pkg::OS_TRIG_B_BIT];

    // Bus handshake: one wait cycle, then a one-cycle answer.
    if (!acc && (i_avs_read || i_avs_write)) begin
      d.bus = pfadc_pkg::BUS_ACK;
    end else begin
      d.bus = pfadc_pkg::BUS_IDLE;
    end

    case (i_avs_address)
      pfadc_pkg::OFS_ONESHOT: rsel = os_rb;
      pfadc_pkg::OFS_CONT: rsel = cont_rb;
      pfadc_pkg::OFS_DEADBAND: rsel = db_rb;
      pfadc_pkg::OFS_RED: rsel = 16'(q.red);
      pfadc_pkg::OFS_FED: rsel = 16'(q.fed);
      pfadc_pkg::OFS_STATUS: rsel = status;
      default: rsel = 16'h0000;
    endcase
    if (!acc && i_avs_read) begin
      d.rdata = {16'h0000, rsel};
    end

    // Shadow transfer chosen by the reload field.
    case (q.reload)
      pfadc_pkg::RLD_ZERO: ld_evt = i_cnt_zero;
      pfadc_pkg::RLD_PERIOD: ld_evt = i_cnt_period;
      pfadc_pkg::RLD_EITHER: ld_evt = i_cnt_zero | i_cnt_period;
      default: ld_evt = 1'b0;
    endcase
    if (ld_evt) begin
      d.cont_active = q.cont_shadow;
    end

    if (wr) begin
      case (i_avs_address)
        pfadc_pkg::OFS_ONESHOT: begin
          d.reload = pfadc_pkg::pfadc_reload_t'(
            os_new[pfadc_pkg::OS_RELOAD_LSB +: 2]);
          d.act_b = os_new[pfadc_pkg::OS_ACT_B_LSB +: 2];
          d.act_a = os_new[pfadc_pkg::OS_ACT_A_LSB +: 2];
        end
        pfadc_pkg::OFS_CONT: begin
          d.cont_shadow = cont_new[3:0];
          if (q.reload == pfadc_pkg::RLD_IMMED) begin
            d.cont_active = cont_new[3:0];
          end
        end
        pfadc_pkg::OFS_DEADBAND: begin
          d.db.half = db_new[pfadc_pkg::DB_HALF_BIT];
          d.db.src = db_new[pfadc_pkg::DB_SRC_LSB +: 2];
          d.db.pol = db_new[pfadc_pkg::DB_POL_LSB +: 2];
          d.db.mode = db_new[pfadc_pkg::DB_MODE_LSB +: 2];
        end
        pfadc_pkg::OFS_RED: d.red = red_new[DELAY_W-1:0];
        pfadc_pkg::OFS_FED: d.fed = fed_new[DELAY_W-1:0];
        default: begin
        end
      endcase
    end

    // A new trigger in the consuming cycle is kept, not lost.
    d.pend_a = (q.pend_a & ~i_time_base_tick) | trig_a;
    d.pend_b = (q.pend_b & ~i_time_base_tick) | trig_b;

    // Mode bit 1 picks the rising path for A, bit 0 the falling
    // path for B; polarity only acts on a delayed path.
    if (q.db.mode[1]) begin
      d.out_a = red_out ^ q.db.pol[0];
    end else begin
      d.out_a = lvl_a;
    end
    if (q.db.mode[0]) begin
      d.out_b = fed_out ^ q.db.pol[1];
    end else begin
      d.out_b = lvl_b;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign o_avs_readdata = q.rdata;
  assign o_avs_waitrequest = q.bus;
  assign o_qualified_out_a = lvl_a;
  assign o_qualified_out_b = lvl_b;
  assign o_db_out_a = q.out_a;
  assign o_db_out_b = q.out_b;

  // ********************************************************
  // Checks
  // ********************************************************
  chk_oneshot_low: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (q.pend_a && i_time_base_tick && q.act_a == 2'b01 &&
     q.cont_active[1:0] != 2'b01 && q.cont_active[1:0] != 2'b10)
    |=> !lvl_a)
    else $error("One-shot clear on A did not drive A low.");

  chk_oneshot_toggle: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (q.pend_a && i_time_base_tick && q.act_a == 2'b11 &&
     q.cont_active[1:0] != 2'b01 && q.cont_active[1:0] != 2'b10)
    |=> lvl_a != $past(lvl_a))
    else $error("One-shot toggle on A did not invert A.");

  chk_cont_b_low: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_time_base_tick && q.cont_active[3:2] == 2'b01) |=> !lvl_b)
    else $error("Continuous low force on B not applied.");

  chk_cont_a_high: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_time_base_tick && q.cont_active[1:0] == 2'b10) |=> lvl_a)
    else $error("Continuous high force on A not applied.");

  chk_immed_load: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (wr && i_avs_address == pfadc_pkg::OFS_CONT &&
     i_avs_byteenable[0] && q.reload == pfadc_pkg::RLD_IMMED)
    |=> q.cont_active == $past(i_avs_writedata[3:0]))
    else $error("Immediate mode write did not reach active force.");

  chk_shadow_hold: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (q.reload != pfadc_pkg::RLD_IMMED && !ld_evt)
    |=> $stable(q.cont_active))
    else $error("Active force changed without a shadow transfer.");

  chk_zero_load: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (q.reload == pfadc_pkg::RLD_ZERO && i_cnt_zero)
    |=> q.cont_active == $past(q.cont_shadow))
    else $error("Shadow not transferred on counter zero.");

  chk_trigger_reads: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (acc && i_avs_read && i_avs_address == pfadc_pkg::OFS_ONESHOT)
    |-> o_avs_readdata[5] == 1'b0 && o_avs_readdata[2] == 1'b0)
    else $error("One-shot trigger bits did not read as zero.");

  chk_reserved_db: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (acc && i_avs_read && i_avs_address == pfadc_pkg::OFS_DEADBAND)
    |-> o_avs_readdata[14:6] == 9'h000)
    else $error("Reserved dead-band bits did not read as zero.");

  chk_bypass: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    q.db.mode == 2'b00
    |=> o_db_out_a == $past(lvl_a) && o_db_out_b == $past(lvl_b))
    else $error("Bypass mode did not pass the qualified outputs.");

  chk_polarity_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (q.db.mode[1] && q.db.pol[0])
    |=> o_db_out_a == !$past(red_out))
    else $error("Rising path on A was not inverted.");

endmodule

// >>> testbench/pfadc_ctrl_tb.sv
`timescale 1ns/1ns
module pfadc_ctrl_tb;
  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic wait_r;
  logic [3:0] ev = 4'h0;
  logic [1:0] act_a = 2'h0;
  logic [1:0] act_b = 2'h0;
  logic qa;
  logic qb;
  logic da;
  logic db;
  logic [31:0] exp_q[$];
  int failures = 0;
  int samples_checked = 0;
  int seed = 32'h3E62;
  logic la = 1'b0;
  logic lb = 1'b0;

  always #25 clk = ~clk;

  pfadc_ctrl dut (
    .i_sys_clk(clk),
    .i_rst_b(rst_b),
    .i_avs_address(adr),
    .i_avs_read(rd),
    .i_avs_write(wr),
    .i_avs_writedata(wdat),
    .i_avs_byteenable(4'h3),
    .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_r),
    .i_time_base_tick(ev[0]),
    .i_tick_x2(ev[3]),
    .i_cnt_zero(ev[1]),
    .i_cnt_period(ev[2]),
    .i_event_action_a(act_a),
    .i_event_action_b(act_b),
    .o_qualified_out_a(qa),
    .o_qualified_out_b(qb),
    .o_db_out_a(da),
    .o_db_out_b(db)
  );

  // ****************************************
  // Checking and reporting
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Read data are taken only at the edge where waitrequest is seen low.
  always @(posedge clk) begin
    if (rd === 1'b1 && wait_r === 1'b0) begin
      if (exp_q.size() == 0) begin
        failures++;
      end else begin
        check(rdat, exp_q.pop_front());
      end
    end
  end

  // ****************************************
  // Bus and event tasks
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    int n;
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= {r[31:16], d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    if (wait_r !== 1'b0) begin
      failures++;
      conclude();
    end else begin
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask

  task automatic write(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic read_expect(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask

  // Bits: 0 tick, 1 zero, 2 period, 3 double-rate tick.
  task automatic pulse(input logic [3:0] m, input int k);
    repeat (k) begin
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 4'h0;
    end
  endtask

  function automatic logic act(input logic l, input logic [1:0] a);
    return a == 2'b01 ? 1'b0 : a == 2'b10 ? 1'b1 : a == 2'b11 ? ~l : l;
  endfunction

  function automatic logic cf(input logic [1:0] c, input logic l,
                              input logic [1:0] a);
    return c == 2'b01 ? 1'b0 : c == 2'b10 ? 1'b1 : act(l, a);
  endfunction

  function automatic logic [31:0] stat(input logic [3:0] c, input logic p,
                                       input logic x, input logic y);
    return {22'h0, 1'b0, p, c, y, x, lb, la};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic [1:0] a2;
    logic tr;
    logic [3:0] nc;
    logic [3:0] ac;
    logic [5:0] m;
    logic ri;
    logic fi;
    logic xa;
    logic xb;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) read_expect(8'(i * 4), 32'h0);
    write(8'h18, 16'hFFFF);
    read_expect(8'h18, 32'h0);
    write(8'h04, 16'hFFFF);
    read_expect(8'h04, 32'h0000000F);
    write(8'h04, 16'h0000);
    write(8'h08, 16'hFFFF);
    read_expect(8'h08, 32'h0000803F);
    write(8'h08, 16'h0000);
    write(8'h0C, 16'hFFFF);
    read_expect(8'h0C, 32'h000003FF);
    write(8'h00, 16'hFFDB);
    read_expect(8'h00, 32'h000000DB);
    $display("test registers done");
    // The last pass writes an action with the trigger left at zero.
    for (int i = 0; i < 5; i++) begin
      a2 = (i == 4) ? 2'b11 : 2'(i);
      tr = (i != 4);
      write(8'h00, {8'h00, 2'b11, 3'b000, tr, a2});
      read_expect(8'h00, {24'h0, 2'b11, 4'h0, a2});
      read_expect(8'h14, stat(4'h0, tr, la, lb));
      pulse(4'h1, 1);
      if (tr) la = act(la, a2);
      read_expect(8'h14, stat(4'h0, 1'b0, la, lb));
    end
    write(8'h00, 16'h00F0);
    read_expect(8'h14, stat(4'h0, 1'b0, la, lb) | 32'h200);
    pulse(4'h1, 1);
    lb = 1'b1;
    read_expect(8'h14, stat(4'h0, 1'b0, la, lb));
    $display("test one-shot done");
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      act_a <= r[1:0];
      act_b <= r[3:2];
      write(8'h04, 16'(c));
      pulse(4'h1, 1);
      la = cf(2'(c), la, r[1:0]);
      lb = cf(2'(c >> 2), lb, r[3:2]);
      read_expect(8'h14, stat(4'(c), 1'b0, la, lb));
      check({31'h0, qa}, {31'h0, la});
      check({31'h0, qb}, {31'h0, lb});
    end
    act_a <= 2'b00;
    act_b <= 2'b00;
    write(8'h04, 16'h0001);
    write(8'h00, 16'h00C6);
    pulse(4'h1, 1);
    la = 1'b0;
    read_expect(8'h14, stat(4'h1, 1'b0, la, lb));
    $display("test continuous done");
    write(8'h04, 16'h0000);
    pulse(4'h1, 1);
    ac = 4'h0;
    for (int i = 0; i < 3; i++) begin
      nc = (i == 1) ? 4'h1 : 4'h2;
      write(8'h00, 16'(i << 6));
      write(8'h04, {12'h0, nc});
      read_expect(8'h04, {28'h0, nc});
      pulse(i == 0 ? 4'h5 : i == 1 ? 4'h3 : 4'h1, 1);
      la = cf(ac[1:0], la, 2'b00);
      read_expect(8'h14, stat(ac, 1'b0, la, lb));
      pulse(i == 1 ? 4'h4 : i == 0 ? 4'h2 : 4'h4, 1);
      read_expect(8'h14, stat(nc, 1'b0, la, lb));
      ac = nc;
      pulse(4'h1, 1);
      la = cf(ac[1:0], la, 2'b00);
      read_expect(8'h14, stat(ac, 1'b0, la, lb));
    end
    $display("test shadow done");
    write(8'h00, 16'h00C0);
    write(8'h0C, 16'h0002);
    write(8'h10, 16'h0003);
    for (int p = 0; p < 2; p++) begin
      nc = (p == 1) ? 4'h9 : 4'h6;
      write(8'h04, {12'h0, nc});
      pulse(4'h1, 1);
      la = (p == 0);
      lb = (p == 1);
      for (int g = 0; g < 64; g++) begin
        m = 6'(g);
        write(8'h08, {10'h0, m});
        pulse(4'h1, 6);
        ri = m[4] ? lb : la;
        fi = m[5] ? lb : la;
        xa = m[1] ? ri ^ m[2] : la;
        xb = m[0] ? fi ^ m[3] : lb;
        read_expect(8'h14, stat(nc, 1'b0, xa, xb));
        check({31'h0, da}, {31'h0, xa});
        check({31'h0, db}, {31'h0, xb});
      end
    end
    $display("test dead-band routing done");
    // Only double-rate steps are given, so the delay can end only once the half-cycle bit is set.
    write(8'h0C, 16'h0004);
    write(8'h08, 16'h0003);
    pulse(4'h1, 6);
    write(8'h04, 16'h0006);
    pulse(4'h1, 1);
    la = 1'b1;
    lb = 1'b0;
    pulse(4'h8, 8);
    read_expect(8'h14, stat(4'h6, 1'b0, 1'b0, 1'b1));
    write(8'h08, 16'h8003);
    pulse(4'h8, 8);
    read_expect(8'h14, stat(4'h6, 1'b0, 1'b1, 1'b1));
    check({31'h0, da}, 32'h00000001);
    $display("test half-cycle done");
    repeat (3) @(posedge clk);
    if (exp_q.size() != 0) failures++;
    conclude();
  end
endmodule
